/* File: src/irq_regs.vh */
// How it works
// R1 - External vector only when pending and mask clear
// R2 - External interrupt wakes processor from Halt
// R3 - Per-source sensitivity selected by configuration field
// R4 - Edge request latched, cleared on routine entry
// R5 - Low enabled pin masks combined source request
// R6 - Peripheral raises only if unmasked and enabled
// R7 - Otherwise peripheral request stays latched, pending
// R8 - Clear by writing zero or status-then-data access
// R9 - Clear sequence also drops pending latch
// R10 - Low-voltage reset flag set by hardware, read-clears
// R11 - Flag undefined when low-voltage detector disabled
// R12 - Short dip under wakeup interval need not set
// R13 - External clock: not in Halt, run above 10MHz
// R14 - Flag survives external and watchdog resets
// R15 - Supply warning flag read-only, hardware level
// R16 - Enabled warning flag rising raises interrupt request
// R17 - Warning interrupt enable is software read/write
// R18 - Warning request cleared on routine entry
`ifndef IRQ_REGS_VH
`define IRQ_REGS_VH
// Register indices; byte address is four times the index.
`define IDX_SYS_INTEGRITY 8'h3a
`define IDX_WARN_THRESHOLD 8'h3e
`define IDX_EXT_CONFIG 8'h40
`define IDX_PIN_ENABLE 8'h41
`define IDX_PERIPH_CONTROL 8'h42
`define IDX_PERIPH_STATUS 8'h43
`define IDX_PERIPH_DATA 8'h44
`define IDX_IRQ_STATUS 8'h45
`define IDX_IRQ_MASK 8'h46
// Field positions in the system integrity register.
`define BIT_WARN_IE 0
`define BIT_WARN_FLAG 1
`define BIT_LV_RESET 2
// Reset values and writable masks.
`define RST_SYS_INTEGRITY 8'h60
`define WMASK_SYS_INTEGRITY 8'h61
`define RST_WARN_THRESHOLD 8'h03
`define WMASK_WARN_THRESHOLD 8'he3
// Sensitivity codes.
`define SENS_LOW_LEVEL 2'h0
`define SENS_RISING 2'h1
`define SENS_FALLING 2'h2
`define SENS_BOTH 2'h3
// Timing: wakeup interval and clock period in ns.
`define WAKEUP_INTERVAL_NS 33000
`define CLK_PERIOD_NS 50
`define WAKEUP_CYCLES ((`WAKEUP_INTERVAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: src/ext_irq_cell.v */
`default_nettype none
`include "irq_regs.vh"
// One external interrupt source: sensitivity decode and request latch.
module ext_irq_cell
(
   input wire pclk,
   input wire presetn,
   input wire src,
   input wire gate,
   input wire [1:0] sens,
   input wire ack,
   output wire pending
);
   reg src_q; // Previous source level for edge detection.
   reg latch_q; // Captured edge request.
   wire rise; // Rising edge seen this cycle.
   wire fall; // Falling edge seen this cycle.
   wire edge_hit; // Edge that matches the selected sensitivity.
   assign rise = src & ~src_q;
   assign fall = ~src & src_q;
   // Sensitivity picks which edge is captured.
   assign edge_hit = (sens == `SENS_RISING) ? rise : // R3
                     (sens == `SENS_FALLING) ? fall :
                     (sens == `SENS_BOTH) ? (rise | fall) : 1'b0;
   // Edge requests latch; entering the routine clears them, a new edge wins.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_q <= 1'b1;
         latch_q <= 1'b0;
      end
      else
      begin
         src_q <= src;
         if (edge_hit)
            latch_q <= 1'b1; // R4
         else if (ack || sens == `SENS_LOW_LEVEL)
            latch_q <= 1'b0; // R4
      end
   end
   // Low-level mode follows the pin; the gate masks a combined source.
   assign pending = gate & ((sens == `SENS_LOW_LEVEL) ? ~src : latch_q); // R5
endmodule // ext_irq_cell
`default_nettype wire

/* File: src/periph_flag_cell.v */
`default_nettype none
// One peripheral status flag with its pending latch and clear paths.
module periph_flag_cell
(
   input wire pclk,
   input wire presetn,
   input wire set_evt,
   input wire wr_zero,
   input wire seq_clear,
   input wire enable,
   input wire imask,
   output wire flag,
   output wire request
);
   reg flag_q; // The flag doubles as the pending latch.
   // Either clear path drops the latch; an event in the same cycle wins.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_q <= 1'b0;
      else if (set_evt)
         flag_q <= 1'b1; // R7
      else if (wr_zero || seq_clear)
         flag_q <= 1'b0; // R8 R9
   end
   assign flag = flag_q;
   // Request only reaches the core while unmasked and enabled.
   assign request = flag_q & enable & ~imask; // R6
endmodule // periph_flag_cell
`default_nettype wire

/* File: src/irq_and_supply_flags.v */
// The APB interface to the registers was left to the implementer.
`default_nettype none
`include "irq_regs.vh"
// Interrupt controller with supply supervision flags, APB register access.
module irq_and_supply_flags
(
   input wire pclk,
   input wire presetn,
   input wire por_n,
   input wire [9:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire imask,
   input wire halt_mode,
   input wire [1:0] ext_ack,
   input wire warn_ack,
   input wire ext_pin0,
   input wire [3:0] ext_group_pins,
   input wire [3:0] periph_event,
   input wire lv_reset_event,
   input wire lv_supply_below,
   input wire lvd_enabled,
   input wire clk_external,
   input wire external_clock_input_fast,
   input wire supply_below_warn,
   output reg [1:0] ext_vector_req,
   output reg wake_halt,
   output reg [3:0] periph_irq,
   output reg warn_irq_req,
   output reg irq
);
   localparam integer WAKEUP_FULL = `WAKEUP_CYCLES; // Least dip length, rounded up.
   localparam [9:0] WAKEUP_CYCLES = WAKEUP_FULL[9:0]; // Cut to the counter width.

   // Decode a word address into a register index; valid only when aligned.
   function [7:0] reg_index;
      input [9:0] addr;
      begin
         reg_index = addr[9:2];
      end
   endfunction

   reg [7:0] sys_q; // Bits 6:5 and bit 0 are stored here.
   reg lv_flag_q; // Low-voltage reset flag, reset only at power-on.
   reg [7:0] warn_thr_q; // Threshold select, steers nothing inside.
   reg [3:0] ext_cfg_q; // Two bits of sensitivity per source.
   reg [3:0] pin_en_q; // Interrupt enable per combined-group pin.
   reg [3:0] per_ctl_q; // Peripheral interrupt enables.
   reg [3:0] armed_q; // Flags seen set during a status access.
   reg [4:0] irq_stat_q; // Sticky summary status.
   reg [4:0] irq_mask_q; // Summary mask, one enables.
   reg warn_flag_q; // Supply warning flag as last sampled.
   reg warn_pend_q; // Pending supply warning interrupt.
   reg [9:0] dip_cnt_q; // Cycles the supply has stayed under threshold.
   reg dip_long_q; // Dip lasted at least the wakeup interval.
   reg [1:0] ext_pend_q; // Previous pending, for event edges.
   reg [3:0] per_req_q; // Previous peripheral requests.

   wire [7:0] idx; // Index of the addressed register.
   wire setup; // Setup or first access cycle awaiting answer.
   wire commit; // Edge at which the transfer completes.
   wire wr; // Write completes this cycle.
   wire rd; // Read completes this cycle.
   wire mapped; // Address hits a register.
   wire group_src; // Combined source level.
   wire [1:0] ext_pend; // Pending external requests.
   wire [3:0] per_flag; // Peripheral flags.
   wire [3:0] per_req; // Peripheral requests toward the core.
   wire [3:0] per_wr_zero; // Write of zero to a set status bit.
   wire per_seq_clr; // Data register access finishing a clear sequence.
   wire warn_rise; // Warning flag just became set.
   wire lv_qualify; // Low-voltage reset should be recorded.
   wire [4:0] irq_events; // One-cycle events into the summary.
   reg [7:0] rd_mux; // Read data before it is registered.

   // Every access gets exactly one wait state.
   // Setup is the first access cycle; commit is the edge that sees pready high.
   // Side effects such as read-clear act only at commit, once per access.
   assign idx = reg_index(paddr);
   assign setup = psel & penable & ~pready;
   assign commit = psel & penable & pready;
   assign wr = commit & pwrite & mapped;
   assign rd = commit & ~pwrite & mapped;
   assign mapped = (paddr[1:0] == 2'h0) &&
                   (idx == `IDX_SYS_INTEGRITY || idx == `IDX_WARN_THRESHOLD ||
                    (idx >= `IDX_EXT_CONFIG && idx <= `IDX_IRQ_MASK));

   // A low level on any enabled group pin holds the combined source low.
   assign group_src = &(ext_group_pins | ~pin_en_q); // R5

   // Both sources use one cell so that edge capture behaves alike.
   // The group needs its own gate: a low pin must hide a request
   // that was latched earlier, not only block new edges.
   // Source 0 is a plain pin; source 1 is the combined group, gated by it.
   ext_irq_cell u_ext0
   (
      .pclk(pclk),
      .presetn(presetn),
      .src(ext_pin0),
      .gate(1'b1),
      .sens(ext_cfg_q[1:0]),
      .ack(ext_ack[0]),
      .pending(ext_pend[0])
   );
   ext_irq_cell u_ext1
   (
      .pclk(pclk),
      .presetn(presetn),
      .src(group_src),
      .gate(group_src),
      .sens(ext_cfg_q[3:2]),
      .ack(ext_ack[1]),
      .pending(ext_pend[1])
   );

   // Status writes clear bits written as zero; the data register ends a sequence.
   assign per_wr_zero = (wr && idx == `IDX_PERIPH_STATUS) ? ~pwdata[3:0] : 4'h0; // R8
   assign per_seq_clr = commit && mapped && idx == `IDX_PERIPH_DATA; // R8

   // One flag cell per peripheral event line.
   // The flag is the pending latch, so a clear also drops the request.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_periph
         periph_flag_cell u_flag
         (
            .pclk(pclk),
            .presetn(presetn),
            .set_evt(periph_event[g]),
            .wr_zero(per_wr_zero[g]),
            .seq_clear(per_seq_clr & armed_q[g]),
            .enable(per_ctl_q[g]),
            .imask(imask),
            .flag(per_flag[g]),
            .request(per_req[g])
         );
      end
   endgenerate

   // Remember which flags were set when status was accessed.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         armed_q <= 4'h0;
      else if (commit && mapped && idx == `IDX_PERIPH_STATUS)
         armed_q <= per_flag; // R8
      else if (per_seq_clr)
         armed_q <= 4'h0; // R9
   end

   // The counter stops at the wakeup interval and then holds the mark.
   // Only power-on reset or the supply rising back clears it, so a low-voltage reset taken
   // during a dip does not restart the measurement.
   // Measure how long the supply stays under the reset threshold.
   always @(posedge pclk or negedge por_n)
   begin
      if (!por_n)
      begin
         dip_cnt_q <= 10'h000;
         dip_long_q <= 1'b0;
      end
      else if (!lv_supply_below)
      begin
         dip_cnt_q <= 10'h000;
         dip_long_q <= 1'b0;
      end
      else if (dip_cnt_q < WAKEUP_CYCLES)
         dip_cnt_q <= dip_cnt_q + 10'h001;
      else
         dip_long_q <= 1'b1; // R12
   end

   // With the external clock the dip length is still measured but never used.
   // Halt stops that clock, so a reset taken in Halt is never recorded.
   // Clock source decides whether a low-voltage reset gets recorded.
   assign lv_qualify = lv_reset_event &&
                       (clk_external ? (!halt_mode && external_clock_input_fast) : dip_long_q); // R12 R13

   // A set and a read in one cycle keep the flag, so no failure is lost.
   // Power-on reset only: other resets leave the record in place.
   always @(posedge pclk or negedge por_n)
   begin
      if (!por_n)
         lv_flag_q <= 1'b0; // R14
      else if (lv_qualify)
         lv_flag_q <= 1'b1; // R10
      else if (rd && idx == `IDX_SYS_INTEGRITY)
         lv_flag_q <= 1'b0; // R10
   end

   // A warning pending when the enable is cleared stays pending.
   // Warning flag tracks the supply; its rising edge raises a request.
   assign warn_rise = supply_below_warn & ~warn_flag_q;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         warn_flag_q <= 1'b0;
         warn_pend_q <= 1'b0;
      end
      else
      begin
         warn_flag_q <= supply_below_warn; // R15
         if (warn_rise && sys_q[`BIT_WARN_IE])
            warn_pend_q <= 1'b1; // R16
         else if (warn_ack)
            warn_pend_q <= 1'b0; // R18
      end
   end

   // Unused bits are masked on write, so reads return only what is stored.
   // Status registers have their own clear paths and are not written here.
   // Software registers; writes land at the completing edge.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sys_q <= `RST_SYS_INTEGRITY;
         warn_thr_q <= `RST_WARN_THRESHOLD;
         ext_cfg_q <= 4'h0;
         pin_en_q <= 4'h0;
         per_ctl_q <= 4'h0;
         irq_mask_q <= 5'h00;
      end
      else if (wr)
      begin
         case (idx)
            `IDX_SYS_INTEGRITY: sys_q <= pwdata[7:0] & `WMASK_SYS_INTEGRITY; // R17
            `IDX_WARN_THRESHOLD: warn_thr_q <= pwdata[7:0] & `WMASK_WARN_THRESHOLD;
            `IDX_EXT_CONFIG: ext_cfg_q <= pwdata[3:0]; // R3
            `IDX_PIN_ENABLE: pin_en_q <= pwdata[3:0];
            `IDX_PERIPH_CONTROL: per_ctl_q <= pwdata[3:0];
            `IDX_IRQ_MASK: irq_mask_q <= pwdata[4:0];
            default: sys_q <= sys_q;
         endcase
      end
   end

   // Each summary bit takes an edge of its source, not its level, so a
   // source that stays high sets the bit once until software clears it.
   // Summary events: external pending rise, peripheral request rise, warning.
   assign irq_events = {warn_rise & sys_q[`BIT_WARN_IE],
                        |(per_req & ~per_req_q),
                        1'b0,
                        ext_pend & ~ext_pend_q};

   // Sticky summary bits; write one clears, a fresh event wins.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_q <= 5'h00;
         ext_pend_q <= 2'h0;
         per_req_q <= 4'h0;
      end
      else
      begin
         ext_pend_q <= ext_pend;
         per_req_q <= per_req;
         if (wr && idx == `IDX_IRQ_STATUS)
            irq_stat_q <= (irq_stat_q & ~pwdata[4:0]) | irq_events;
         else
            irq_stat_q <= irq_stat_q | irq_events;
      end
   end

   // With the detector off, software must treat the flag bit as meaningless.
   // The zero it reads then carries no information.
   // Read multiplexer; an undefined low-voltage flag reads as zero.
   always @*
   begin
      rd_mux = 8'h00;
      case (idx)
         `IDX_SYS_INTEGRITY:
         begin
            rd_mux = sys_q;
            rd_mux[`BIT_LV_RESET] = lv_flag_q & lvd_enabled; // R11
            rd_mux[`BIT_WARN_FLAG] = warn_flag_q; // R15
         end
         `IDX_WARN_THRESHOLD: rd_mux = warn_thr_q;
         `IDX_EXT_CONFIG: rd_mux = {4'h0, ext_cfg_q};
         `IDX_PIN_ENABLE: rd_mux = {4'h0, pin_en_q};
         `IDX_PERIPH_CONTROL: rd_mux = {4'h0, per_ctl_q};
         `IDX_PERIPH_STATUS: rd_mux = {4'h0, per_flag};
         `IDX_PERIPH_DATA: rd_mux = {4'h0, armed_q};
         `IDX_IRQ_STATUS: rd_mux = {3'h0, irq_stat_q};
         `IDX_IRQ_MASK: rd_mux = {3'h0, irq_mask_q};
         default: rd_mux = 8'h00;
      endcase
   end

   // One wait state: answer registered in the first access cycle.
   // Registering prdata costs a cycle but keeps outputs glitch free.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         pready <= 1'b1;
         pslverr <= ~mapped;
         prdata <= (mapped && !pwrite) ? {24'h000000, rd_mux} : 32'h00000000;
      end
      else
      begin
         prdata <= 32'h00000000; // Read data stands only while pready is high.
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // The global mask acts after the latches, so a masked request stays
   // pending and appears as soon as the mask is lifted.
   // The summary interrupt ignores the global mask; the core applies it.
   // Core-facing outputs, all registered.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_vector_req <= 2'h0;
         wake_halt <= 1'b0;
         periph_irq <= 4'h0;
         warn_irq_req <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         ext_vector_req <= ext_pend & {2{~imask}}; // R1
         wake_halt <= halt_mode & (|ext_pend); // R2
         periph_irq <= per_req; // R6
         warn_irq_req <= warn_pend_q & ~imask;
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end
endmodule // irq_and_supply_flags
`default_nettype wire

/* File: bench/irq_flags_checker_assertions.sv */
`default_nettype none
// Watches the bus handshake and the request outputs at the block's ports.
module irq_flags_checker
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire logic imask,
   input wire logic halt_mode,
   input wire logic warn_ack,
   input wire logic supply_below_warn,
   input wire logic [1:0] ext_vector_req,
   input wire logic wake_halt,
   input wire logic [3:0] periph_irq,
   input wire logic warn_irq_req
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // The slave answers after exactly one wait state and never holds pready.
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
   a_vec_unmasked: assert property (ext_vector_req != 2'h0 |-> !$past(imask)) else $error("vector masked");
   a_wake_in_halt: assert property (wake_halt |-> $past(halt_mode)) else $error("wake outside halt");
   a_periph_unmasked: assert property (periph_irq != 4'h0 |-> !$past(imask)) else $error("periph masked");
   a_warn_unmasked: assert property (warn_irq_req |-> !$past(imask)) else $error("warning masked");
   // A steady supply keeps a new warning from hiding a missed clear.
   a_warn_ack_clr: assert property (warn_ack && $stable(supply_below_warn) ##1 $stable(supply_below_warn)
      |=> !warn_irq_req) else $error("warning not cleared");
endmodule // irq_flags_checker
bind irq_and_supply_flags irq_flags_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .imask(imask),
   .halt_mode(halt_mode), .warn_ack(warn_ack), .supply_below_warn(supply_below_warn),
   .ext_vector_req(ext_vector_req), .wake_halt(wake_halt), .periph_irq(periph_irq),
   .warn_irq_req(warn_irq_req));
`default_nettype wire

/* File: bench/core_model.sv */
`default_nettype none
// Core stand-in: enters a routine for each request while allowed to.
module core_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ack_en,
   input wire logic [1:0] ext_vector_req,
   input wire logic warn_irq_req,
   output logic [1:0] ext_ack,
   output logic warn_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] busy_q; // Hold-off so a request that is still falling is not taken twice.
   // Acknowledge pulses last one cycle, then the core waits three cycles before taking another request.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_ack <= 2'h0;
         warn_ack <= 1'h0;
         busy_q <= 2'h0;
      end
      else
      begin
         ext_ack <= 2'h0;
         warn_ack <= 1'h0;
         if (busy_q != 2'h0)
            busy_q <= busy_q - 2'h1;
         else if (ack_en && (ext_vector_req != 2'h0 || warn_irq_req))
         begin
            ext_ack <= ext_vector_req;
            warn_ack <= warn_irq_req;
            busy_q <= 2'h3;
         end
      end
   end
endmodule // core_model
`default_nettype wire

/* File: bench/tb.sv */
`default_nettype none
`include "irq_regs.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [9:0] addr_si = 10'(4 * `IDX_SYS_INTEGRITY);
   localparam logic [9:0] addr_th = 10'(4 * `IDX_WARN_THRESHOLD);
   localparam logic [9:0] addr_ec = 10'(4 * `IDX_EXT_CONFIG);
   localparam logic [9:0] addr_pe = 10'(4 * `IDX_PIN_ENABLE);
   localparam logic [9:0] addr_pc = 10'(4 * `IDX_PERIPH_CONTROL);
   localparam logic [9:0] addr_ps = 10'(4 * `IDX_PERIPH_STATUS);
   localparam logic [9:0] addr_pd = 10'(4 * `IDX_PERIPH_DATA);
   localparam logic [9:0] addr_is = 10'(4 * `IDX_IRQ_STATUS);
   localparam logic [9:0] addr_im = 10'(4 * `IDX_IRQ_MASK);
   localparam logic [3:0] pin_start = 4'hd; // Pin level before the edge, per sensitivity code.
   logic pclk = 1'h0, presetn = 1'h0, por_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [9:0] paddr = 10'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, wake_halt, warn_irq_req, irq, warn_ack, ack_en = 1'h0;
   logic imask = 1'h1, halt_mode = 1'h0, ext_pin0 = 1'h1, lv_reset_event = 1'h0, lv_supply_below = 1'h0;
   logic lvd_enabled = 1'h1, clk_external = 1'h0, external_clock_input_fast = 1'h0, supply_below_warn = 1'h0;
   logic [3:0] ext_group_pins = 4'hf, periph_event = 4'h0, periph_irq;
   logic [1:0] ext_ack, ext_vector_req;
   integer errors = 0, tests_run = 0, s;
   always #25 pclk = ~pclk;
   irq_and_supply_flags i_dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .imask(imask), .halt_mode(halt_mode), .ext_ack(ext_ack), .warn_ack(warn_ack),
      .ext_pin0(ext_pin0), .ext_group_pins(ext_group_pins), .periph_event(periph_event),
      .lv_reset_event(lv_reset_event), .lv_supply_below(lv_supply_below), .lvd_enabled(lvd_enabled),
      .clk_external(clk_external), .external_clock_input_fast(external_clock_input_fast), .supply_below_warn(supply_below_warn),
      .ext_vector_req(ext_vector_req), .wake_halt(wake_halt), .periph_irq(periph_irq),
      .warn_irq_req(warn_irq_req), .irq(irq));
   core_model i_core (.pclk(pclk), .presetn(presetn), .ack_en(ack_en), .ext_vector_req(ext_vector_req),
      .warn_irq_req(warn_irq_req), .ext_ack(ext_ack), .warn_ack(warn_ack));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // One APB transfer; the answer is taken at the edge that samples pready high.
   task automatic xfer(input logic [9:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // If pready never rises, only the watchdog ends this wait; values are those sampled at the edge.
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rchk(input logic [9:0] a, input logic [31:0] e, input string n);
      xfer(a, 1'h0, 32'h0);
      chk(n, e, rd);
   endtask
   // Waits n edges, then looks at outputs when they are settled.
   task automatic settle(input integer n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic pev();
      @(posedge pclk) periph_event <= 4'h1;
      @(posedge pclk) periph_event <= 4'h0;
   endtask
   // A supply dip of the given length ending in a low-voltage reset event.
   task automatic lv_dip(input integer dip, input logic ext, input logic fast, input logic hlt);
      @(posedge pclk);
      clk_external <= ext;
      external_clock_input_fast <= fast;
      halt_mode <= hlt;
      lv_supply_below <= 1'h1;
      repeat (dip) @(posedge pclk);
      lv_reset_event <= 1'h1;
      @(posedge pclk);
      lv_reset_event <= 1'h0;
      lv_supply_below <= 1'h0;
      halt_mode <= 1'h0;
   endtask
   task automatic lv_try(input integer dip, input logic ext, input logic fast, input logic hlt,
      input logic [31:0] e);
      lv_dip(dip, ext, fast, hlt);
      rchk(addr_si, e, "lv flag");
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Cuts a hang short; the sequence needs about 6000 cycles.
   initial
   begin
      repeat (30000) @(posedge pclk);
      errors++;
      report_and_stop();
   end
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      por_n <= 1'h1;
      rchk(addr_si, 32'h60, "sysint reset");
      rchk(addr_th, 32'h03, "thresh reset");
      rchk(10'h3fc, 32'h0, "unmapped");
      chk("slverr", 32'h1, er);
      xfer(addr_th, 1'h1, 32'hff);
      rchk(addr_th, 32'he3, "thresh rw");
      xfer(addr_si, 1'h1, 32'hff);
      rchk(addr_si, 32'h61, "sysint rw");
      $display("test registers done");
      @(posedge pclk);
      imask <= 1'h0;
      supply_below_warn <= 1'h1;
      settle(4);
      chk("warn req", 32'h1, warn_irq_req);
      chk("irq masked", 32'h0, irq);
      rchk(addr_si, 32'h63, "warn flag");
      xfer(addr_im, 1'h1, 32'h10);
      settle(2);
      chk("irq raised", 32'h1, irq);
      @(posedge pclk) ack_en <= 1'h1;
      settle(6);
      chk("warn ack", 32'h0, warn_irq_req);
      @(posedge pclk) ack_en <= 1'h0;
      xfer(addr_is, 1'h1, 32'h10);
      settle(2);
      chk("irq cleared", 32'h0, irq);
      @(posedge pclk) supply_below_warn <= 1'h0;
      settle(3);
      rchk(addr_si, 32'h61, "warn gone");
      $display("test warning done");
      @(posedge pclk) imask <= 1'h1;
      xfer(addr_pc, 1'h1, 32'h1);
      pev();
      settle(3);
      chk("periph masked", 32'h0, periph_irq);
      rchk(addr_ps, 32'h1, "periph pending");
      @(posedge pclk) imask <= 1'h0;
      settle(3);
      chk("periph raised", 32'h1, periph_irq);
      xfer(addr_ps, 1'h1, 32'h0);
      settle(3);
      chk("write zero", 32'h0, periph_irq);
      pev();
      rchk(addr_ps, 32'h1, "periph again");
      xfer(addr_pd, 1'h0, 32'h0);
      settle(3);
      chk("status data", 32'h0, periph_irq);
      xfer(addr_pc, 1'h1, 32'h0);
      pev();
      rchk(addr_ps, 32'h1, "disabled set");
      xfer(addr_pd, 1'h0, 32'h0);
      xfer(addr_pc, 1'h1, 32'h1);
      settle(3);
      chk("pending lost", 32'h0, periph_irq);
      $display("test peripheral done");
      for (s = 0; s < 4; s++)
      begin
         xfer(addr_ec, 1'h1, s);
         @(posedge pclk);
         ext_pin0 <= pin_start[s];
         ack_en <= 1'h1;
         settle(6);
         @(posedge pclk);
         ack_en <= 1'h0;
         ext_pin0 <= ~pin_start[s];
         settle(3);
         chk("ext edge", 32'h1, ext_vector_req[0]);
         @(posedge pclk) ack_en <= 1'h1;
         settle(6);
         chk("ext after ack", (s == 0) ? 32'h1 : 32'h0, ext_vector_req[0]);
      end
      @(posedge pclk);
      ack_en <= 1'h0;
      imask <= 1'h1;
      xfer(addr_ec, 1'h1, 32'h1);
      @(posedge pclk) ext_pin0 <= 1'h1;
      settle(3);
      chk("ext masked", 32'h0, ext_vector_req[0]);
      @(posedge pclk) halt_mode <= 1'h1;
      settle(3);
      chk("wake", 32'h1, wake_halt);
      @(posedge pclk);
      imask <= 1'h0;
      halt_mode <= 1'h0;
      settle(3);
      chk("ext unmasked", 32'h1, ext_vector_req[0]);
      xfer(addr_pe, 1'h1, 32'hf);
      xfer(addr_ec, 1'h1, 32'h5);
      @(posedge pclk) ext_group_pins <= 4'he;
      settle(1);
      @(posedge pclk) ext_group_pins <= 4'hf;
      settle(3);
      chk("group rise", 32'h1, ext_vector_req[1]);
      @(posedge pclk) ext_group_pins <= 4'he;
      settle(3);
      chk("group low", 32'h0, ext_vector_req[1]);
      $display("test external done");
      lv_try(700, 1'h0, 1'h0, 1'h0, 32'h65);
      rchk(addr_si, 32'h61, "read clears");
      lv_try(700, 1'h0, 1'h0, 1'h0, 32'h65);
      lv_try(700, 1'h0, 1'h0, 1'h0, 32'h65);
      lv_dip(700, 1'h0, 1'h0, 1'h0);
      @(posedge pclk) presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      rchk(addr_si, 32'h64, "survives reset");
      lv_try(100, 1'h0, 1'h0, 1'h0, 32'h60);
      lv_try(700, 1'h1, 1'h0, 1'h0, 32'h60);
      lv_try(700, 1'h1, 1'h1, 1'h0, 32'h64);
      lv_try(700, 1'h1, 1'h1, 1'h1, 32'h60);
      @(posedge pclk) lvd_enabled <= 1'h0;
      lv_try(700, 1'h0, 1'h0, 1'h0, 32'h60);
      $display("test low voltage done");
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
